// >>> hw/core_halt_run_control.sv
// Core activity-state controller: power halt, debug halt and run control
//
// Contract
// - Power unit can halt core to sleep or restart it; sleep is reported.
// - Debug controller strap picks run or Debug Mode out of reset.
// - Debug controller halt enters Debug Mode; its run request resumes.
// - Debug Mode is reported; breakpoint or trigger entry raises cross trigger.
// - Active and Sleep handled in logic; Power Off needs no logic.
// - Quiesced means issue stopped and read, write, fetch-miss traffic empty.
// - Leave debug halt next cycle only when every set source is released.
// - Acknowledge debug resume, controller run, or both resume and run together.
// - Resume or run with no matching halt source does nothing.
// - Resume needs debug-halt bit; controller run needs controller-halt bit.
// - Both halt source bits clear whenever Debug Mode is left.
// - Single step ignored between controller halt and controller run.
// - Halt status only in power halt; debug status in debug or step.
// - Cycle counter runs, stops in power halt, obeys stop-count in debug halt but always counts the step cycle.
// - DMA accesses are allowed in every activity state.
// - Fine gating active except in reset and boot; enhanced gating added in power halt.
// - Any debug halt action outranks power or firmware halts.
// - Halt handshake: ack after halt, drop ack after request drops.
// - Run handshake: ack after resume, drop ack after request drops.
// - Power halt ignored in Debug Mode, honoured after exit if still held.
// - No acknowledge when already in the requested activity state.
`timescale 1ns/1ps
module core_halt_run_control (
    input wire logic ref_clk,                     // Core clock
    input wire logic arst_n,                      // Async reset, active low
    input wire halt_run_pkg::pmu_in_s pmu,        // Power unit requests
    input wire halt_run_pkg::mpc_in_s multi_processor_debug_controller,        // Debug controller requests
    input wire logic mpc_reset_run,               // Strap: 1 run, 0 debug
    input wire halt_run_pkg::dbg_in_s dbg,        // Core debug actions
    input wire halt_run_pkg::quiet_s quiet,       // Outstanding traffic idle
    input wire logic [3:0] addr,                  // Register address
    input wire logic [31:0] wdata,                // Register write data
    input wire logic wr,                          // Write strobe
    input wire logic rd,                          // Read strobe
    output logic [31:0] rdata,                    // Read data, next cycle
    output logic cpu_halt_ack,                    // Halt handshake ack
    output logic cpu_run_ack,                     // Run handshake ack
    output logic cpu_halt_status,                 // Core in power halt
    output logic debug_mode_status,               // Core in Debug Mode
    output logic dbg_resume_ack,                  // Debug resume ack pulse
    output logic mpc_run_ack,                     // Controller run ack pulse
    output logic bkpt_hit_status,                 // Cross-trigger level
    output logic issue_stop,                      // Stop issuing instructions
    output logic step_go,                         // Execute one step pulse
    output logic fine_gate_en,                    // Fine-grain gating on
    output logic enh_gate_en,                     // Enhanced gating on
    output logic dma_allow                        // DMA accesses accepted
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    halt_run_pkg::pmu_in_s pmu_s;
    halt_run_pkg::mpc_in_s mpc_s;

    sync_2ff #(.WIDTH(2)) u_pmu_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .din(pmu),
        .dout(pmu_s)
    );

    sync_2ff #(.WIDTH(2)) u_mpc_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .din(multi_processor_debug_controller),
        .dout(mpc_s)
    );

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        return a == o;
    endfunction

    // ------------------------------------------------------------------
    // Activity state machine
    // ------------------------------------------------------------------
    halt_run_pkg::activity_e state, next_state;
    logic dbg_bit, next_dbg_bit;
    logic mpc_bit, next_mpc_bit;
    logic by_pmu, next_by_pmu;
    logic next_bkpt, next_halt_ack, next_run_ack;
    logic next_resume_ack, next_mpc_run_ack, next_step_go;
    logic core_halt, mpc_halt, enter_dbg, fw_halt;
    logic resume_eff, run_eff, release_ok, step_eff;
    logic stop_count;

    assign core_halt = dbg.halt_req | dbg.bkpt | dbg.trig;
    assign mpc_halt = mpc_s.halt_req;
    assign enter_dbg = core_halt | mpc_halt;
    assign fw_halt = wr & hit(addr, halt_run_pkg::CTRL_OFS)
                     & wdata[halt_run_pkg::CTRL_FW_HALT_BIT];
    // Requests without their halt bit are dropped
    assign resume_eff = dbg.resume_req & ~dbg.step & dbg_bit;
    assign run_eff = mpc_s.run_req & mpc_bit;
    assign release_ok = (~dbg_bit | resume_eff) & (~mpc_bit | run_eff);
    // Step only when no controller halt is pending
    assign step_eff = dbg.resume_req & dbg.step & dbg_bit & ~mpc_bit;

    always_comb
    begin
        next_state = state;
        next_dbg_bit = dbg_bit;
        next_mpc_bit = mpc_bit;
        next_by_pmu = by_pmu;
        next_bkpt = bkpt_hit_status;
        // Acks hold until their request drops; a new set wins
        next_halt_ack = cpu_halt_ack & pmu_s.halt_req;
        next_run_ack = cpu_run_ack & pmu_s.run_req;
        next_resume_ack = 1'b0;
        next_mpc_run_ack = 1'b0;
        next_step_go = 1'b0;
        unique case (state)
            halt_run_pkg::boot_st:
            begin
                if (mpc_reset_run)
                    next_state = halt_run_pkg::running_st;
                else
                begin
                    next_state = halt_run_pkg::debug_halted_state;
                    next_mpc_bit = 1'b1;
                end
            end
            halt_run_pkg::running_st,
            halt_run_pkg::quiesce_st,
            halt_run_pkg::power_halted_state:
            begin
                if (enter_dbg)
                begin
                    next_state = halt_run_pkg::debug_halted_state;
                    next_dbg_bit = core_halt;
                    next_mpc_bit = mpc_halt;
                    next_bkpt = dbg.bkpt | dbg.trig;
                end
                else if (state == halt_run_pkg::running_st)
                begin
                    // Held power halt re-enters here after Debug Mode
                    if (pmu_s.halt_req | fw_halt)
                    begin
                        next_state = halt_run_pkg::quiesce_st;
                        next_by_pmu = pmu_s.halt_req;
                    end
                end
                else if (state == halt_run_pkg::quiesce_st)
                begin
                    if (&quiet)
                    begin
                        next_state = halt_run_pkg::power_halted_state;
                        next_halt_ack = by_pmu;
                    end
                end
                else if (pmu_s.run_req)
                begin
                    next_state = halt_run_pkg::running_st;
                    next_run_ack = 1'b1;
                end
            end
            halt_run_pkg::debug_halted_state:
            begin
                next_dbg_bit = dbg_bit | core_halt;
                next_mpc_bit = mpc_bit | mpc_halt;
                next_bkpt = bkpt_hit_status | dbg.bkpt | dbg.trig;
                if (!enter_dbg && release_ok)
                begin
                    next_state = halt_run_pkg::running_st;
                    next_resume_ack = dbg_bit;
                    next_mpc_run_ack = mpc_bit;
                    next_dbg_bit = 1'b0;
                    next_mpc_bit = 1'b0;
                    next_bkpt = 1'b0;
                end
                else if (!enter_dbg && step_eff)
                begin
                    next_state = halt_run_pkg::step_st;
                    next_step_go = 1'b1;
                end
            end
            halt_run_pkg::step_st:
                next_state = halt_run_pkg::debug_halted_state;
            default:
                next_state = halt_run_pkg::boot_st;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= halt_run_pkg::boot_st;
            dbg_bit <= 1'b0;
            mpc_bit <= 1'b0;
            by_pmu <= 1'b0;
            bkpt_hit_status <= 1'b0;
            cpu_halt_ack <= 1'b0;
            cpu_run_ack <= 1'b0;
            dbg_resume_ack <= 1'b0;
            mpc_run_ack <= 1'b0;
            step_go <= 1'b0;
            cpu_halt_status <= 1'b0;
            debug_mode_status <= 1'b0;
            issue_stop <= 1'b1;
            fine_gate_en <= 1'b0;
            enh_gate_en <= 1'b0;
            dma_allow <= 1'b1;
        end
        else
        begin
            state <= next_state;
            dbg_bit <= next_dbg_bit;
            mpc_bit <= next_mpc_bit;
            by_pmu <= next_by_pmu;
            bkpt_hit_status <= next_bkpt;
            cpu_halt_ack <= next_halt_ack;
            cpu_run_ack <= next_run_ack;
            dbg_resume_ack <= next_resume_ack;
            mpc_run_ack <= next_mpc_run_ack;
            step_go <= next_step_go;
            cpu_halt_status <=
                next_state == halt_run_pkg::power_halted_state;
            debug_mode_status <=
                next_state inside {halt_run_pkg::debug_halted_state,
                                   halt_run_pkg::step_st};
            issue_stop <=
                next_state inside {halt_run_pkg::boot_st,
                                   halt_run_pkg::quiesce_st,
                                   halt_run_pkg::power_halted_state,
                                   halt_run_pkg::debug_halted_state};
            // Power Off is handled by power gating outside this block
            fine_gate_en <= next_state != halt_run_pkg::boot_st;
            enh_gate_en <=
                next_state == halt_run_pkg::power_halted_state;
            dma_allow <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers and cycle counter
    // ------------------------------------------------------------------
    logic [63:0] cycle, next_cycle;
    logic next_stop_count;
    logic [31:0] next_rdata, status_word;
    logic cycle_inc;

    always_comb
    begin
        status_word = '0;
        status_word[halt_run_pkg::ST_STATE_LSB +: halt_run_pkg::ST_STATE_W] =
            state;
        status_word[halt_run_pkg::ST_DBG_BIT] = dbg_bit;
        status_word[halt_run_pkg::ST_MPC_BIT] = mpc_bit;
        status_word[halt_run_pkg::ST_BKPT_BIT] = bkpt_hit_status;
        cycle_inc = (state inside {halt_run_pkg::running_st,
                                   halt_run_pkg::quiesce_st,
                                   halt_run_pkg::step_st})
                    | (state == halt_run_pkg::debug_halted_state
                       & ~stop_count);
        next_cycle = cycle + {63'h0, cycle_inc};
        next_stop_count = stop_count;
        if (wr && hit(addr, halt_run_pkg::CTRL_OFS))
            next_stop_count = wdata[halt_run_pkg::CTRL_STOP_COUNT_BIT];
        if (wr && hit(addr, halt_run_pkg::CYCLE_LO_OFS))
            next_cycle[31:0] = wdata;
        if (wr && hit(addr, halt_run_pkg::CYCLE_HI_OFS))
            next_cycle[63:32] = wdata;
        next_rdata = halt_run_pkg::RDATA_IDLE;
        if (rd)
        begin
            unique case (addr)
                halt_run_pkg::CTRL_OFS:
                    next_rdata = {31'h0, stop_count};
                halt_run_pkg::STATUS_OFS:
                    next_rdata = status_word;
                halt_run_pkg::CYCLE_LO_OFS:
                    next_rdata = cycle[31:0];
                halt_run_pkg::CYCLE_HI_OFS:
                    next_rdata = cycle[63:32];
                default:
                    next_rdata = halt_run_pkg::RDATA_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cycle <= halt_run_pkg::CYCLE_RST;
            stop_count <= halt_run_pkg::STOP_COUNT_RST;
            rdata <= halt_run_pkg::RDATA_IDLE;
        end
        else
        begin
            cycle <= next_cycle;
            stop_count <= next_stop_count;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    halt_status_only_a: assert property (
        cpu_halt_status |-> state == halt_run_pkg::power_halted_state)
        else $error("halt status outside power halt");

    exit_clears_bits_a: assert property (
        $fell(debug_mode_status) |-> !dbg_bit && !mpc_bit)
        else $error("halt bits kept after debug exit");

    run_needs_bit_a: assert property (
        state == halt_run_pkg::debug_halted_state && !mpc_bit && dbg_bit
        && mpc_s.run_req && !dbg.resume_req && !enter_dbg
        |=> state == halt_run_pkg::debug_halted_state && !mpc_run_ack)
        else $error("run request acted without controller halt");

    both_ack_a: assert property (
        state == halt_run_pkg::debug_halted_state && dbg_bit && mpc_bit
        && resume_eff && run_eff && !enter_dbg
        |=> dbg_resume_ack && mpc_run_ack
            && state == halt_run_pkg::running_st)
        else $error("joint release not acknowledged together");

    halt_ack_quiet_a: assert property (
        $rose(cpu_halt_ack) |-> $past(&quiet) && issue_stop)
        else $error("halt acknowledged before quiesce");

    halt_ack_drop_a: assert property (
        cpu_halt_ack && !pmu_s.halt_req |=> !cpu_halt_ack)
        else $error("halt ack held after request dropped");

    run_no_ack_a: assert property (
        state == halt_run_pkg::running_st && pmu_s.run_req && !cpu_run_ack
        |=> !cpu_run_ack)
        else $error("run ack while already running");

    cycle_hold_a: assert property (
        state == halt_run_pkg::power_halted_state && !wr
        |=> cycle == $past(cycle))
        else $error("cycle counter moved in power halt");

    debug_first_a: assert property (
        state == halt_run_pkg::running_st && core_halt
        |=> state == halt_run_pkg::debug_halted_state ##1 debug_mode_status)
        else $error("debug halt lost priority");

    step_blocked_a: assert property (
        state == halt_run_pkg::debug_halted_state && mpc_bit
        && dbg.resume_req && dbg.step && !run_eff
        |=> state == halt_run_pkg::debug_halted_state && !step_go)
        else $error("step taken under controller halt");

    gating_a: assert property (
        enh_gate_en |-> fine_gate_en && cpu_halt_status)
        else $error("enhanced gating outside power halt");

    power_cycle_c: cover property (
        $rose(cpu_halt_ack) ##[1:40] $rose(cpu_run_ack));
    joint_release_c: cover property (dbg_resume_ack && mpc_run_ack);
    step_c: cover property (step_go ##1 debug_mode_status);
    held_halt_c: cover property (
        $fell(debug_mode_status) && pmu_s.halt_req);

endmodule // core_halt_run_control

// >>> hw/halt_run_pkg.sv
// Shared constants, register map and carrier types of the halt/run control
package halt_run_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] CYCLE_LO_OFS = 4'h8;
    localparam logic [3:0] CYCLE_HI_OFS = 4'hC;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_STOP_COUNT_BIT = 0;
    localparam int CTRL_FW_HALT_BIT = 1;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_STATE_W = 3;
    localparam int ST_DBG_BIT = 4;
    localparam int ST_MPC_BIT = 5;
    localparam int ST_BKPT_BIT = 6;
    localparam logic STOP_COUNT_RST = 1'b0;
    localparam logic [63:0] CYCLE_RST = 64'h0;
    localparam logic [31:0] RDATA_IDLE = 32'h0;

    // ------------------------------------------------------------------
    // Activity states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        boot_st,
        running_st,
        quiesce_st,
        power_halted_state,
        debug_halted_state,
        step_st
    } activity_e;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic halt_req;
        logic run_req;
    } pmu_in_s;

    typedef struct packed {
        logic halt_req;
        logic run_req;
    } mpc_in_s;

    typedef struct packed {
        logic halt_req;
        logic resume_req;
        logic step;
        logic bkpt;
        logic trig;
    } dbg_in_s;

    typedef struct packed {
        logic rd_buf_empty;
        logic wr_buf_empty;
        logic ic_miss_idle;
    } quiet_s;

endpackage

// >>> hw/sync_2ff.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,            // Core clock
    input wire logic arst_n,             // Async reset, active low
    input wire logic [WIDTH-1:0] din,    // Asynchronous levels
    output logic [WIDTH-1:0] dout        // Synchronised levels
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= '0;
            dout <= '0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // sync_2ff

// >>> sim/core_halt_run_control_tb.sv
// Self-checking testbench of the core halt and run controller
`timescale 1ns/1ps
module core_halt_run_control_tb;
    logic ref_clk, arst_n, mpc_reset_run, wr, rd, go_halt, go_run;
    halt_run_pkg::pmu_in_s pmu;
    halt_run_pkg::mpc_in_s multi_processor_debug_controller;
    halt_run_pkg::dbg_in_s dbg;
    halt_run_pkg::quiet_s quiet;
    logic [3:0] addr, lag;
    logic [31:0] wdata, rdata, d0, d1;
    logic cpu_halt_ack, cpu_run_ack, cpu_halt_status, debug_mode_status;
    logic dbg_resume_ack, mpc_run_ack, bkpt_hit_status, issue_stop, step_go;
    logic fine_gate_en, enh_gate_en, dma_allow;
    int n_mismatch, num_checks, cycles, i;

    core_halt_run_control u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .pmu(pmu), .multi_processor_debug_controller(multi_processor_debug_controller), .mpc_reset_run(mpc_reset_run), .dbg(dbg),
        .quiet(quiet), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cpu_halt_ack(cpu_halt_ack), .cpu_run_ack(cpu_run_ack),
        .cpu_halt_status(cpu_halt_status),
        .debug_mode_status(debug_mode_status),
        .dbg_resume_ack(dbg_resume_ack), .mpc_run_ack(mpc_run_ack),
        .bkpt_hit_status(bkpt_hit_status), .issue_stop(issue_stop),
        .step_go(step_go), .fine_gate_en(fine_gate_en),
        .enh_gate_en(enh_gate_en), .dma_allow(dma_allow));

    pmu_model u_pmu (.ref_clk(ref_clk), .arst_n(arst_n), .go_halt(go_halt),
        .go_run(go_run), .lag(lag), .cpu_halt_ack(cpu_halt_ack),
        .cpu_run_ack(cpu_run_ack), .pmu(pmu));

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            tally_and_finish;
        end
    end

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] status_exp(input logic [2:0] st,
        input logic db, input logic mb, input logic bk);
        return {25'h0, bk, mb, db, 1'b0, st};
    endfunction

    function automatic logic sel(input int w);
        case (w)
            0: return cpu_halt_ack;
            1: return cpu_run_ack;
            2: return mpc_run_ack;
            default: return cpu_halt_status;
        endcase
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Bounded wait on a design output, then compare it
    task automatic wait_for(input string name, input int w, input logic v);
        repeat (40)
        begin
            if (sel(w) === v)
                break;
            cyc(1);
        end
        chk(name, sel(w), v);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic cycle_delta(input logic [31:0] exp, input string name);
        reg_rd(halt_run_pkg::CYCLE_LO_OFS, d0);
        reg_rd(halt_run_pkg::CYCLE_LO_OFS, d1);
        chk(name, d1 - d0, exp);
    endtask

    task automatic dbg_pulse(input halt_run_pkg::dbg_in_s v);
        @(posedge ref_clk);
        dbg <= v;
        @(posedge ref_clk);
        dbg <= '0;
        #1;
    endtask

    task automatic pmu_cmd(input logic h, input logic r);
        @(posedge ref_clk);
        go_halt <= h;
        go_run <= r;
        @(posedge ref_clk);
        go_halt <= 1'b0;
        go_run <= 1'b0;
    endtask

    task automatic pmu_run;
        pmu_cmd(1'b0, 1'b1);
        wait_for("run_ack", 1, 1'b1);
        wait_for("run_ack drop", 1, 1'b0);
    endtask

    initial
    begin
        void'($urandom(32'h599426CB));
        {arst_n, wr, rd, go_halt, go_run, multi_processor_debug_controller, dbg} = '0;
        {addr, wdata, lag, mpc_reset_run, quiet} = {36'h0, 4'h0, 1'b1, 3'h7};
        repeat (6) @(posedge ref_clk);
        #1;
        chk("issue_stop rst", issue_stop, 1'b1);
        chk("dma_allow rst", dma_allow, 1'b1);
        @(posedge ref_clk);
        arst_n <= 1'b1;
        cyc(2);
        chk("issue_stop run", issue_stop, 1'b0);
        chk("fine_gate run", fine_gate_en, 1'b1);
        @(posedge ref_clk);
        quiet <= 3'($urandom) & 3'b011;
        pmu_cmd(1'b1, 1'b0);
        cyc(8);
        chk("halt_ack busy", cpu_halt_ack, 1'b0);
        chk("issue_stop q", issue_stop, 1'b1);
        @(posedge ref_clk);
        quiet <= 3'h7;
        wait_for("halt_ack", 0, 1'b1);
        chk("halt_status", cpu_halt_status, 1'b1);
        chk("enh_gate", enh_gate_en, 1'b1);
        chk("dma halt", dma_allow, 1'b1);
        wait_for("halt_ack drop", 0, 1'b0);
        cycle_delta(32'h0, "cycle halt");
        pmu_cmd(1'b1, 1'b0);
        cyc(8);
        chk("halt_ack again", cpu_halt_ack, 1'b0);
        pmu_cmd(1'b1, 1'b1);
        lag <= 4'h3;
        pmu_run();
        chk("halt_status run", cpu_halt_status, 1'b0);
        chk("enh_gate run", enh_gate_en, 1'b0);
        cycle_delta(32'h2, "cycle run");
        pmu_cmd(1'b0, 1'b1);
        cyc(8);
        chk("run_ack again", cpu_run_ack, 1'b0);
        pmu_cmd(1'b1, 1'b1);
        dbg_pulse(5'h10);
        chk("dbg mode", debug_mode_status, 1'b1);
        pmu_cmd(1'b1, 1'b0);
        cyc(8);
        chk("halt_ack dbg", cpu_halt_ack, 1'b0);
        chk("enh_gate dbg", enh_gate_en, 1'b0);
        reg_rd(halt_run_pkg::STATUS_OFS, d0);
        chk("status dbg", d0, status_exp(3'h4, 1'b1, 1'b0, 1'b0));
        @(posedge ref_clk);
        multi_processor_debug_controller <= 2'b01;
        cyc(4);
        chk("run no bit", debug_mode_status, 1'b1);
        reg_wr(halt_run_pkg::CTRL_OFS, 32'h1);
        cycle_delta(32'h0, "cycle stop");
        reg_wr(halt_run_pkg::CTRL_OFS, 32'h0);
        cycle_delta(32'h2, "cycle dbg");
        dbg_pulse(5'h0C);
        chk("step_go", step_go, 1'b1);
        chk("dbg step", debug_mode_status, 1'b1);
        cyc(2);
        dbg_pulse(5'h08);
        chk("resume_ack", dbg_resume_ack, 1'b1);
        chk("dbg exit", debug_mode_status, 1'b0);
        wait_for("halt_ack late", 0, 1'b1);
        wait_for("halt_ack late drop", 0, 1'b0);
        pmu_run();
        @(posedge ref_clk);
        multi_processor_debug_controller <= 2'b10;
        cyc(4);
        chk("mpc halt", debug_mode_status, 1'b1);
        dbg_pulse(5'h10);
        dbg_pulse(5'h0C);
        chk("step masked", step_go, 1'b0);
        dbg_pulse(5'h08);
        chk("resume held", dbg_resume_ack, 1'b0);
        reg_rd(halt_run_pkg::STATUS_OFS, d0);
        chk("status both", d0, status_exp(3'h4, 1'b1, 1'b1, 1'b0));
        @(posedge ref_clk);
        multi_processor_debug_controller <= 2'b01;
        dbg <= 5'h08;
        wait_for("mpc_run_ack", 2, 1'b1);
        chk("both acks", dbg_resume_ack, 1'b1);
        @(posedge ref_clk);
        dbg <= '0;
        multi_processor_debug_controller <= '0;
        cyc(2);
        chk("no action", debug_mode_status, 1'b0);
        reg_rd(halt_run_pkg::STATUS_OFS, d0);
        chk("status clear", d0, status_exp(3'h1, 1'b0, 1'b0, 1'b0));
        for (i = 0; i < 2; i++)
        begin
            dbg_pulse(i == 0 ? 5'h02 : 5'h01);
            chk("bkpt hit", bkpt_hit_status, 1'b1);
            reg_rd(halt_run_pkg::STATUS_OFS, d0);
            chk("status bkpt", d0, status_exp(3'h4, 1'b1, 1'b0, 1'b1));
            dbg_pulse(5'h08);
            chk("bkpt clear", bkpt_hit_status, 1'b0);
        end
        reg_wr(halt_run_pkg::CTRL_OFS, 32'h2);
        wait_for("fw halt", 3, 1'b1);
        chk("fw enh_gate", enh_gate_en, 1'b1);
        chk("fw no ack", cpu_halt_ack, 1'b0);
        pmu_run();
        repeat (30)
        begin
            d0 = $urandom;
            reg_wr({d0[3:2], d0[1:0] | 2'b01}, d0);
            reg_rd({d0[3:2], d0[1:0] | 2'b01}, d1);
            chk("unmapped", d1, 32'h0);
        end
        @(posedge ref_clk);
        arst_n <= 1'b0;
        mpc_reset_run <= 1'b0;
        cyc(3);
        @(posedge ref_clk);
        arst_n <= 1'b1;
        cyc(2);
        chk("strap dbg", debug_mode_status, 1'b1);
        reg_rd(halt_run_pkg::STATUS_OFS, d0);
        chk("status strap", d0, status_exp(3'h4, 1'b0, 1'b1, 1'b0));
        @(posedge ref_clk);
        multi_processor_debug_controller <= 2'b01;
        wait_for("strap run_ack", 2, 1'b1);
        tally_and_finish;
    end
endmodule // core_halt_run_control_tb

// >>> sim/pmu_model.sv
// Behavioural power management unit driving the halt and run handshakes
`timescale 1ns/1ps
module pmu_model (
    input wire logic ref_clk,          // Core clock
    input wire logic arst_n,           // Async reset, active low
    input wire logic go_halt,          // Start a halt handshake
    input wire logic go_run,           // Start a run handshake
    input wire logic [3:0] lag,        // Extra cycles before dropping
    input wire logic cpu_halt_ack,     // Halt acknowledge
    input wire logic cpu_run_ack,      // Run acknowledge
    output halt_run_pkg::pmu_in_s pmu  // Requests to the core
);
    logic [3:0] cnt;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pmu <= '0;
            cnt <= 4'h0;
        end
        else if (go_halt && go_run)
        begin
            // Both commands at once withdraw any open request
            pmu <= '0;
            cnt <= 4'h0;
        end
        else
        begin
            if (go_halt)
                pmu.halt_req <= 1'b1;
            if (go_run)
                pmu.run_req <= 1'b1;
            if ((pmu.halt_req && cpu_halt_ack) || (pmu.run_req && cpu_run_ack))
            begin
                cnt <= cnt + 4'h1;
                if (cnt >= lag)
                begin
                    pmu <= '0;
                    cnt <= 4'h0;
                end
            end
        end
    end
endmodule // pmu_model
